/* File: hdl/itp_bank.sv */
// byte-wide control and status bank held in flip-flops
// assumes one write port and one read port, both on sys_clk
module itp_bank #(
	parameter int DEPTH = 256
) (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_b,
	// access
	input  wire logic       wr_en,
	input  wire logic [7:0] wr_addr,
	input  wire logic [7:0] wr_data,
	input  wire logic [7:0] rd_addr,
	output logic      [7:0] rd_data
);
	import itp_pkg::*;

	// elaboration refuses a bank the 8-bit pointer cannot address
	if (DEPTH < 1 || DEPTH > (1 << ITP_PTR_W)) begin : g_depth_bad
		$error("itp_bank depth out of range");
	end

	logic [7:0] mem [DEPTH];

	for (genvar i = 0; i < DEPTH; i++) begin : g_cell
		always_ff @(posedge sys_clk or negedge rst_b) begin
			if (!rst_b)
				mem[i] <= ITP_BANK_RESET;
			else if (wr_en && wr_addr == 8'(i))
				mem[i] <= wr_data;
		end
	end

	// unmapped pointers read as zero
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			rd_data <= ITP_BANK_RESET;
		else if (int'(rd_addr) < DEPTH)
			rd_data <= mem[rd_addr];
		else
			rd_data <= 8'h00;
	end
endmodule : itp_bank

/* File: hdl/itp_pkg.sv */
// constants shared by the two-wire target port and its register bank
// assumes the bank is byte wide and addressed by an 8-bit pointer
package itp_pkg;
	localparam int        ITP_SYS_CLK_HZ   = 125_000_000;
	localparam int        ITP_LINK_KBPS    = 400;
	localparam logic [5:0] ITP_ADDR_UPPER  = 6'h16;
	localparam logic [7:0] ITP_PTR_RESET   = 8'h00;
	localparam logic [7:0] ITP_BANK_RESET  = 8'h00;
	localparam int        ITP_PTR_W        = 8;
	localparam int        ITP_DATA_W       = 8;
	localparam logic [2:0] ITP_BIT_LAST    = 3'h7;
	localparam logic [2:0] ITP_BIT_FIRST   = 3'h0;
endpackage : itp_pkg

/* File: hdl/itp_sync.sv */
// two-flop level synchroniser
// assumes d comes from outside the clock's domain
module itp_sync (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// level
	input  wire logic d,
	output logic      q
);
	logic meta;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta <= 1'b1;
			q    <= 1'b1;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule : itp_sync

/* File: hdl/itp_target.sv */
// two-wire serial target port giving register access to the byte bank
// assumes scl/sda/chip enable/strap are asynchronous pins; scl is oversampled
// What this block does
// (R01) respond only while chip enable is high
// (R02) registers stay reachable in low-power link state
// (R03) standard framing, fast mode up to 400 kbps
// (R04) match address 010110X, low bit from strap
// (R05) master sends 0x5a/0x5b or 0x58/0x59
// (R06) acknowledge own address, write or read
// (R07) first written byte is pointer, acknowledged
// (R08) acknowledge every written data byte
// (R09) master ends write with stop
// (R10) unpointed read starts at register zero
// (R11) read starts at previously written pointer
// (R12) send next byte only after master ack
// (R13) master acks wanted bytes, ends with stop
// (R14) pointer-only write sets later read start
// (R15) every bank register reachable only here
// (R16) pointer increments after each data byte; a read byte the master nacks does not advance it
module itp_target #(
	parameter int DEPTH = 256
) (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_b,
	// chip pins
	input  wire logic chip_en,
	input  wire logic addr_strap,
	input  wire logic link_ulps,
	// two-wire bus
	input  wire logic scl_in,
	input  wire logic sda_in,
	output logic      sda_out,
	output logic      sda_oe,
	// status
	output logic      busy
);
	import itp_pkg::*;

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic scl_s, sda_s, en_s, strap_s;

	itp_sync u_scl (.clk(sys_clk), .rst_b(rst_b), .d(scl_in), .q(scl_s));
	itp_sync u_sda (.clk(sys_clk), .rst_b(rst_b), .d(sda_in), .q(sda_s));
	itp_sync u_en (.clk(sys_clk), .rst_b(rst_b), .d(chip_en), .q(en_s));
	itp_sync u_str (.clk(sys_clk), .rst_b(rst_b), .d(addr_strap), .q(strap_s));

	logic scl_d, sda_d;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	// ----------------------------------------------------------------
	// bus events
	// ----------------------------------------------------------------
	// oversampling at 125 MHz covers fast mode many times over (R03)
	logic scl_rise, scl_fall, start_ev, stop_ev;
	assign scl_rise = scl_s && !scl_d;
	assign scl_fall = !scl_s && scl_d;
	assign start_ev = scl_s && scl_d && sda_d && !sda_s; // R03
	assign stop_ev  = scl_s && scl_d && !sda_d && sda_s; // R03

	// ----------------------------------------------------------------
	// state machine
	// ----------------------------------------------------------------
	typedef enum logic [6:0] {
		ST_IDLE  = 7'b0000001,
		ST_ADDR  = 7'b0000010,
		ST_AACK  = 7'b0000100,
		ST_WRX   = 7'b0001000,
		ST_WACK  = 7'b0010000,
		ST_RTX   = 7'b0100000,
		ST_RACK  = 7'b1000000
	} itp_state_t;

	itp_state_t state;
	logic [2:0] bit_cnt;
	logic [7:0] shreg;
	logic [7:0] ptr;
	logic       ptr_phase;
	logic       ack_hold;
	logic       wr_en;
	logic [7:0] wr_data;
	logic [7:0] rd_data;
	logic [7:0] tx_byte;
	logic       addr_hit;
	logic       master_ack;

	assign addr_hit = (shreg[6:1] == ITP_ADDR_UPPER) && (shreg[0] == strap_s); // R04

	// ulps does not gate the port; only chip enable does (R02)
	logic port_on;
	assign port_on = en_s; // R01 R02

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state     <= ST_IDLE;
			bit_cnt   <= ITP_BIT_FIRST;
			shreg     <= 8'h00;
			ptr_phase <= 1'b0;
			master_ack <= 1'b0;
		end else if (!port_on || stop_ev) begin
			state     <= ST_IDLE; // R01 R09 R13
			bit_cnt   <= ITP_BIT_FIRST;
			ptr_phase <= 1'b0;
		end else if (start_ev) begin
			state     <= ST_ADDR; // repeated start too
			bit_cnt   <= ITP_BIT_FIRST;
			ptr_phase <= 1'b0;
		end else begin
			unique case (state)
				ST_IDLE: begin
				end
				ST_ADDR: begin
					if (scl_rise) begin
						if (bit_cnt == ITP_BIT_LAST) begin
							// last bit is direction
							if (addr_hit) begin
								master_ack <= sda_s; // direction kept here
								state      <= ST_AACK; // R06
							end else begin
								state <= ST_IDLE;
							end
						end else begin
							shreg <= {shreg[6:0], sda_s};
						end
						bit_cnt <= bit_cnt + 3'h1;
					end
				end
				ST_AACK: begin
					// ack ends on the falling edge after the ack clock
					if (scl_fall && ack_hold) begin
						bit_cnt <= ITP_BIT_FIRST;
						state   <= master_ack ? ST_RTX : ST_WRX;
						ptr_phase <= !master_ack; // R07
					end
				end
				ST_WRX: begin
					if (scl_rise) begin
						shreg   <= {shreg[6:0], sda_s};
						bit_cnt <= bit_cnt + 3'h1;
						if (bit_cnt == ITP_BIT_LAST)
							state <= ST_WACK; // R07 R08
					end
				end
				ST_WACK: begin
					if (scl_fall && ack_hold) begin
						ptr_phase <= 1'b0;
						bit_cnt   <= ITP_BIT_FIRST;
						state     <= ST_WRX;
					end
				end
				ST_RTX: begin
					if (scl_fall) begin
						bit_cnt <= bit_cnt + 3'h1;
						if (bit_cnt == ITP_BIT_LAST)
							state <= ST_RACK;
					end
				end
				ST_RACK: begin
					if (scl_rise)
						master_ack <= !sda_s;
					if (scl_fall && ack_hold) begin
						bit_cnt <= ITP_BIT_FIRST;
						state   <= master_ack ? ST_RTX : ST_IDLE; // R12
					end
				end
			endcase
		end
	end

	// ack bit window: set on the fall that opens the ack slot
	// a read byte ends on a fall, so its ack slot opens on that same fall
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			ack_hold <= 1'b0;
		else if (!port_on || stop_ev || start_ev)
			ack_hold <= 1'b0;
		else if (scl_fall)
			ack_hold <= ((state == ST_AACK || state == ST_WACK || state == ST_RACK)
			             && !ack_hold)
			            || (state == ST_RTX && bit_cnt == ITP_BIT_LAST); // R12
	end

	// ----------------------------------------------------------------
	// register pointer and bank access
	// ----------------------------------------------------------------
	logic wack_rise, rack_load;
	assign wack_rise = (state == ST_WACK) && scl_fall && ack_hold;
	assign rack_load = (state == ST_RACK) && scl_fall && ack_hold && master_ack;

	// pointer survives between transfers, so a pointer-only write sets read start
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			ptr <= ITP_PTR_RESET; // R10
		else if (wack_rise && ptr_phase)
			ptr <= shreg; // R07 R11 R14
		else if (wack_rise || rack_load)
			ptr <= ptr + 8'h01; // R16
	end

	assign wr_en   = wack_rise && !ptr_phase; // R08 R15
	assign wr_data = shreg;

	itp_bank #(.DEPTH(DEPTH)) u_bank (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.wr_en   (wr_en),
		.wr_addr (ptr),
		.wr_data (wr_data),
		.rd_addr (ptr),
		.rd_data (rd_data)
	);

	// load the outgoing byte after the ack-slot close; the pointer moves on
	// that edge and the bank read is registered, so wait two cycles for data
	logic [1:0] load_pipe;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_byte   <= 8'h00;
			load_pipe <= 2'h0;
		end else begin
			load_pipe <= {load_pipe[0],
			              (state == ST_AACK && scl_fall && ack_hold && master_ack)
			              || rack_load};
			if (load_pipe[1])
				tx_byte <= rd_data; // R10 R11 R16
			else if (state == ST_RTX && scl_fall)
				tx_byte <= {tx_byte[6:0], 1'b0};
		end
	end

	// ----------------------------------------------------------------
	// sda drive (open drain: only pulls low)
	// ----------------------------------------------------------------
	logic drive_low;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			drive_low <= 1'b0;
		else if (!port_on || stop_ev || start_ev)
			drive_low <= 1'b0;
		else if (ack_hold && (state == ST_AACK || state == ST_WACK))
			drive_low <= 1'b1; // R06 R07 R08
		else if (state == ST_RTX && load_pipe == 2'h0)
			drive_low <= !tx_byte[7]; // R10 R12
		else
			drive_low <= 1'b0;
	end

	assign sda_out = 1'b0;
	assign sda_oe  = drive_low;
	assign busy    = (state != ST_IDLE);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_stop;
		stop_ev;
	endsequence

	property p_idle_after_stop;
		@(posedge sys_clk) disable iff (!rst_b) s_stop |=> (state == ST_IDLE);
	endproperty

	enable_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R01
		!en_s |=> !busy ##1 !sda_oe) else $error("port active while disabled");
	stop_idle_a: assert property (p_idle_after_stop) // R09
		else $error("stop did not idle port");
	ulps_free_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R02
		(en_s && start_ev && link_ulps) |=> state == ST_ADDR)
		else $error("port blocked in low power");
	addr_ack_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R06
		(state == ST_AACK && ack_hold && en_s && !stop_ev && !start_ev) |=> sda_oe)
		else $error("address not acknowledged");
	wrong_addr_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R04
		(state == ST_ADDR && scl_rise && bit_cnt == ITP_BIT_LAST && !addr_hit
		 && en_s && !stop_ev && !start_ev) |=> state == ST_IDLE)
		else $error("foreign address accepted");
	ptr_load_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R07
		(wack_rise && ptr_phase) |=> ptr == $past(shreg))
		else $error("pointer not loaded");
	ptr_inc_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R16
		(rack_load || (wack_rise && !ptr_phase)) |=> ptr == $past(ptr) + 8'h01)
		else $error("pointer not advanced");
	nack_end_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R12
		(state == ST_RACK && scl_fall && ack_hold && !master_ack && en_s
		 && !stop_ev && !start_ev) |=> state == ST_IDLE ##1 !sda_oe)
		else $error("sent after nack");
	wr_store_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R08
		wr_en |-> !ptr_phase && state == ST_WACK)
		else $error("store outside data byte");

	// ----------------------------------------------------------------
	// read path and ack release checks
	// ----------------------------------------------------------------
	// the ack slot of a read byte opens on the fall that ends it
	sequence s_last_tx_fall;
		state == ST_RTX && scl_fall && bit_cnt == ITP_BIT_LAST && en_s;
	endsequence

	sequence s_tx_open;
		(state == ST_AACK || state == ST_RACK) && scl_fall && ack_hold && master_ack;
	endsequence

	sequence s_ack_close;
		(state == ST_AACK || state == ST_WACK) && scl_fall && ack_hold;
	endsequence

	// a stale bank word here would repeat the previous byte
	property p_tx_from_bank;
		@(posedge sys_clk) disable iff (!rst_b)
		s_tx_open |-> ##3 (tx_byte == ((int'(ptr) < DEPTH) ? u_bank.mem[ptr] : 8'h00));
	endproperty

	// our ack must be gone before the master drives the next bit
	property p_ack_release;
		@(posedge sys_clk) disable iff (!rst_b)
		s_ack_close |-> ##2 !sda_oe;
	endproperty

	rack_open_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R12
		s_last_tx_fall |=> state == ST_RACK && ack_hold)
		else $error("read ack slot not opened");
	tx_bank_a: assert property (p_tx_from_bank) // R10 R11 R16
		else $error("read byte not from pointer");
	ack_release_a: assert property (p_ack_release) // R08
		else $error("ack held into next bit");
	master_turn_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R12
		state == ST_RACK |=> !sda_oe)
		else $error("sda driven in master ack slot");
	rack_more_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R12
		(rack_load && en_s) |=> state == ST_RTX && bit_cnt == ITP_BIT_FIRST)
		else $error("no byte after master ack");
endmodule : itp_target

/* File: testbench/i2c_register_target_port_tb.sv */
// self-checking bench for the two-wire register target port
// assumes the master model paces the bus from its own link clock
module i2c_register_target_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk    = 1'b0;
	logic link_clk   = 1'b0;
	logic rst_b      = 1'b0;
	logic chip_en    = 1'b1;
	logic addr_strap = 1'b1;
	logic link_ulps  = 1'b0;
	logic scl;
	logic sda_drv;
	logic sda_out;
	logic sda_oe;
	logic busy;
	wire  sda_wire;
	int   err_count  = 0;
	int   tests_run  = 0;
	// ---------------------------------------------
	// clocks, wire and instances
	// ---------------------------------------------
	always #4 sys_clk = ~sys_clk;
	initial begin
		#5;
		forever #16 link_clk = ~link_clk;
	end
	// pull-up: released by both parties reads high
	assign sda_wire = sda_drv & ~(sda_oe & ~sda_out);
	itp_target #(.DEPTH(256)) dut_u (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.chip_en   (chip_en),
		.addr_strap(addr_strap),
		.link_ulps (link_ulps),
		.scl_in    (scl),
		.sda_in    (sda_wire),
		.sda_out   (sda_out),
		.sda_oe    (sda_oe),
		.busy      (busy)
	);
	itp_master_model m_u (
		.link_clk(link_clk),
		.sda_in  (sda_wire),
		.scl     (scl),
		.sda_drv (sda_drv)
	);
	// ---------------------------------------------
	// shared tasks
	// ---------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
			err_count++;
		end
	endtask : chk
	task automatic probe(input logic [7:0] adr, input logic exp_ack);
		logic a;
		m_u.start_c();
		m_u.wr_byte(adr, a);
		chk({7'h00, a}, {7'h00, exp_ack});
		m_u.stop_c();
	endtask : probe
	task automatic wr(input logic [7:0] adr, input logic [7:0] b[$]);
		logic a;
		m_u.start_c();
		m_u.wr_byte(adr, a);
		chk({7'h00, a}, 8'h01);
		foreach (b[i]) begin
			m_u.wr_byte(b[i], a);
			chk({7'h00, a}, 8'h01);
		end
		m_u.stop_c();
	endtask : wr
	task automatic rd(input logic [7:0] adr, input logic [7:0] exp[$]);
		logic       a;
		logic [7:0] v;
		m_u.start_c();
		m_u.wr_byte(adr, a);
		chk({7'h00, a}, 8'h01);
		foreach (exp[i]) begin
			m_u.rd_byte(i < exp.size() - 1, v);
			chk(v, exp[i]);
		end
		// after the nack the port must leave sda released
		m_u.rd_byte(1'b0, v);
		chk(v, 8'hff);
		m_u.stop_c();
		chk({7'h00, busy}, 8'h00);
	endtask : rd
	task automatic settle();
		repeat (8) @(posedge sys_clk);
	endtask : settle
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : summarize
	// ---------------------------------------------
	// scenarios
	// ---------------------------------------------
	task automatic s_reset_read();
		rd(8'h5b, '{8'h00});
	endtask : s_reset_read
	task automatic s_write_read();
		wr(8'h5a, '{8'h10, 8'hab, 8'hcd});
		wr(8'h5a, '{8'h10});
		rd(8'h5b, '{8'hab, 8'hcd});
	endtask : s_write_read
	task automatic s_wrap_lowpower();
		@(posedge sys_clk);
		link_ulps <= 1'b1;
		wr(8'h5a, '{8'hff, 8'h12, 8'h34});
		wr(8'h5a, '{8'hff});
		rd(8'h5b, '{8'h12, 8'h34});
		@(posedge sys_clk);
		link_ulps <= 1'b0;
	endtask : s_wrap_lowpower
	task automatic s_strap();
		@(posedge sys_clk);
		addr_strap <= 1'b0;
		settle();
		probe(8'h5a, 1'b0);
		wr(8'h58, '{8'h10});
		rd(8'h59, '{8'hab});
		@(posedge sys_clk);
		addr_strap <= 1'b1;
		settle();
	endtask : s_strap
	task automatic s_enable();
		@(posedge sys_clk);
		chip_en <= 1'b0;
		settle();
		probe(8'h5a, 1'b0);
		@(posedge sys_clk);
		chip_en <= 1'b1;
		settle();
		probe(8'h5a, 1'b1);
	endtask : s_enable
	// ---------------------------------------------
	// main sequence and hang guard
	// ---------------------------------------------
	initial begin
		repeat (12) @(posedge sys_clk);
		rst_b <= 1'b1;
		settle();
		s_reset_read();
		s_write_read();
		s_wrap_lowpower();
		s_strap();
		s_enable();
		summarize();
	end
	initial begin
		repeat (100000) @(posedge sys_clk);
		err_count++;
		summarize();
	end
endmodule : i2c_register_target_port_tb

/* File: testbench/itp_master_model.sv */
// two-wire bus master model that drives the target port from the far side
// assumes the bench resolves the open-drain sda wire with a pull-up
module itp_master_model (
	// pacing clock
	input  wire logic link_clk,
	// bus
	input  wire logic sda_in,
	output logic      scl,
	output logic      sda_drv
);
	timeunit 1ns;
	timeprecision 1ps;
	// half bit of 40 link cycles keeps scl just under 400 kbps
	localparam int QTR = 20;
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge link_clk);
	endtask : tick
	// scl stands high between frames, sda released to the pull-up
	task automatic start_c();
		sda_drv <= 1'b1;
		tick(QTR);
		scl <= 1'b1;
		tick(QTR);
		sda_drv <= 1'b0;
		tick(QTR);
		scl <= 1'b0;
		tick(QTR);
	endtask : start_c
	task automatic stop_c();
		sda_drv <= 1'b0;
		tick(QTR);
		scl <= 1'b1;
		tick(QTR);
		sda_drv <= 1'b1;
		tick(2 * QTR);
	endtask : stop_c
	// sda only changes a quarter bit after scl falls
	task automatic bit_x(input logic b, output logic r);
		sda_drv <= b;
		tick(QTR);
		scl <= 1'b1;
		tick(QTR);
		r = sda_in;
		tick(QTR);
		scl <= 1'b0;
		tick(QTR);
	endtask : bit_x
	task automatic byte_x(input logic [7:0] d, output logic [7:0] q);
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], q[i]);
		end
	endtask : byte_x
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic [7:0] q;
		logic       r;
		byte_x(d, q);
		bit_x(1'b1, r);
		ack = ~r;
	endtask : wr_byte
	task automatic rd_byte(input logic more, output logic [7:0] q);
		logic r;
		byte_x(8'hff, q);
		bit_x(~more, r);
	endtask : rd_byte
endmodule : itp_master_model
